// ### gpom_board_model.sv
`default_nettype none
module gpom_board_model (
  input wire logic pin_oe,
  input wire logic pin_drv,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // pin wire with board pull-down
  // ----------------------------------------------------------------
  // undriven pin falls low, never keeps the last level
  assign pin_level = pin_oe ? pin_drv : 1'h0;
endmodule
`default_nettype wire

// ### gpom_pin2_mux.sv
// Operation
// - bits 4:2 pick group: rx 0-3, device status, reserved, csi tx 0-1
// - rx group, selector 100 drives that port's lock
// - rx group, selector 101 drives that port's pass
// - rx group, selector 110 frame valid, 111 line valid
// - device group: 000 output level bit, 001 or of enabled locks
// - device group: 010 and of enabled locks; 101-111 reserved
// - tx group: 000 and of selected passes, 001 or of them
// - tx group: 010 frame valid, 011 line valid of that port
// - tx group: 100 synchronized, 101 port interrupt, 111 reserved
// - bit 1 is the level driven when register value is chosen
//
// Chosen here: the AHB-Lite interface to the registers.
`default_nettype none
module gpom_pin2_mux (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire gpom_pkg::gpom_rx_stat_t [3:0] rx_stat,
  input wire logic [3:0] rx_port_enable,
  input wire logic frame_sync,
  input wire gpom_pkg::gpom_tx_stat_t [1:0] tx_stat,
  input wire logic pin2_in,
  output logic pin2_out,
  output logic pin2_oe,
  output logic pin2_in_level
);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  gpom_pkg::gpom_ctrl_t ctrl_q;
  logic wr_pend_q;
  logic rd_hit_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic access;

  // zero wait states: the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  assign access = hsel && hready && (htrans == gpom_pkg::HTRANS_NONSEQ
    || htrans == gpom_pkg::HTRANS_SEQ);
  assign addr_ok = haddr == gpom_pkg::PIN2_CTRL_ADDR;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_pend_q <= 1'b0;
      rd_hit_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= access && hwrite && addr_ok;
      rd_hit_q <= access && !hwrite && addr_ok;
    end
  end

  // write data arrives one cycle after its address phase
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ctrl_q <= gpom_pkg::PIN2_CTRL_RESET;
    else if (wr_pend_q)
      ctrl_q <= hwdata[7:0];
  end

  // read data is captured at the address edge so it stands in data phase
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      hrdata_q <= gpom_pkg::RDATA_ZERO;
    else if (access && !hwrite)
      hrdata_q <= addr_ok ? {24'h00_0000, ctrl_q} : gpom_pkg::RDATA_ZERO;
  end

  // ----------------------------------------------------------------------
  // selection logic
  // ----------------------------------------------------------------------
  function automatic logic rx_pick(
    input gpom_pkg::gpom_rx_stat_t st,
    input logic [2:0] sel
  );
    logic r;
    r = 1'b0;
    unique case (sel)
      gpom_pkg::SEL_0: r = st.rx_remote_pin[0];
      gpom_pkg::SEL_1: r = st.rx_remote_pin[1];
      gpom_pkg::SEL_2: r = st.rx_remote_pin[2];
      gpom_pkg::SEL_3: r = st.rx_remote_pin[3];
      gpom_pkg::SEL_4: r = st.lock;
      gpom_pkg::SEL_5: r = st.pass;
      gpom_pkg::SEL_6: r = st.frame_valid;
      gpom_pkg::SEL_7: r = st.line_valid;
    endcase
    return r;
  endfunction

  function automatic logic tx_pick(
    input gpom_pkg::gpom_tx_stat_t st,
    input logic [3:0] pass,
    input logic [2:0] sel
  );
    logic r;
    r = 1'b0;
    unique case (sel)
      // no pass selected gives and=0 rather than a vacuous 1
      gpom_pkg::SEL_0: r = |st.pass_select
        && &(pass | ~st.pass_select);
      gpom_pkg::SEL_1: r = |(pass & st.pass_select);
      gpom_pkg::SEL_2: r = st.frame_valid;
      gpom_pkg::SEL_3: r = st.line_valid;
      gpom_pkg::SEL_4: r = st.synced;
      gpom_pkg::SEL_5: r = st.irq;
      gpom_pkg::SEL_6: r = 1'b0;
      gpom_pkg::SEL_7: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [3:0] rx_locks;
  logic [3:0] rx_pass;
  logic dev_sig;
  logic sel_sig;

  always_comb
  begin
    for (int i = 0; i < gpom_pkg::NUM_RX; i++)
    begin
      rx_locks[i] = rx_stat[i].lock;
      rx_pass[i] = rx_stat[i].pass;
    end
  end

  always_comb
  begin
    dev_sig = 1'b0;
    unique case (ctrl_q.pin2_signal_selector)
      gpom_pkg::SEL_0: dev_sig = ctrl_q.pin2_output_level;
      gpom_pkg::SEL_1: dev_sig = |(rx_locks & rx_port_enable);
      // no port enabled reads as not locked
      gpom_pkg::SEL_2: dev_sig = |rx_port_enable
        && &(rx_locks | ~rx_port_enable);
      gpom_pkg::SEL_3: dev_sig = |rx_port_enable
        && &(rx_pass | ~rx_port_enable);
      gpom_pkg::SEL_4: dev_sig = frame_sync;
      default: dev_sig = 1'b0;
    endcase
  end

  always_comb
  begin
    sel_sig = 1'b0;
    unique case (ctrl_q.pin2_source_group)
      gpom_pkg::SRC_RX0, gpom_pkg::SRC_RX1,
      gpom_pkg::SRC_RX2, gpom_pkg::SRC_RX3:
        sel_sig = rx_pick(rx_stat[ctrl_q.pin2_source_group[1:0]],
          ctrl_q.pin2_signal_selector);
      gpom_pkg::SRC_DEV: sel_sig = dev_sig;
      gpom_pkg::SRC_RSVD: sel_sig = 1'b0;
      gpom_pkg::SRC_TX0: sel_sig = tx_pick(tx_stat[0], rx_pass,
        ctrl_q.pin2_signal_selector);
      gpom_pkg::SRC_TX1: sel_sig = tx_pick(tx_stat[1], rx_pass,
        ctrl_q.pin2_signal_selector);
    endcase
  end

  // ----------------------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------------------
  // registered so the pin never glitches on mux decode
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pin2_out <= 1'b0;
    else
      pin2_out <= ctrl_q.pin2_drive_enable && sel_sig;
  end

  // enable follows the register one cycle late, in step with the level
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pin2_oe <= 1'b0;
    else
      pin2_oe <= ctrl_q.pin2_drive_enable;
  end

  // pin read back; inputs are taken as synchronous already
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pin2_in_level <= 1'b0;
    else
      pin2_in_level <= pin2_in;
  end

endmodule
`default_nettype wire

// ### gpom_pin2_mux_props.sv
`default_nettype none
module gpom_pin2_mux_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pin2_in,
  input wire logic pin2_out,
  input wire logic pin2_oe,
  input wire logic pin2_in_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // bus and pin checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic ap;
  logic wr;
  assign ap = hsel && hready && htrans == gpom_pkg::HTRANS_NONSEQ;
  assign wr = ap && hwrite && haddr == gpom_pkg::PIN2_CTRL_ADDR;
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_reset_quiet: assert property (disable iff (1'h0)
    reset |=> !pin2_oe && !pin2_out && hrdata == '0)
    else $error("outputs not cleared by reset");
  a_off_quiet: assert property (!pin2_oe |-> !pin2_out)
    else $error("pin level high while undriven");
  a_pin_sample: assert property (pin2_in_level == $past(pin2_in))
    else $error("pin input copy wrong");
  a_upper_zero: assert property (hrdata[31:8] == '0)
    else $error("upper read bits not zero");
  a_enable_on: assert property (wr ##1 hwdata[0] |=> ##1 pin2_oe)
    else $error("driver not enabled after write");
  a_enable_off: assert property (wr ##1 !hwdata[0] |=> ##1 !pin2_oe)
    else $error("driver not released after write");
  a_level_out: assert property (
    wr ##1 hwdata[7:0] == 8'h13 |=> ##1 pin2_out)
    else $error("register level not driven");
  a_miss_zero: assert property (ap && !hwrite &&
    haddr != gpom_pkg::PIN2_CTRL_ADDR |=> hrdata == '0)
    else $error("unmapped read not zero");
  c_write: cover property (wr);
  c_read: cover property (ap && !hwrite);
  c_drive: cover property (pin2_oe && pin2_out);
endmodule
bind gpom_pin2_mux gpom_pin2_mux_props gpom_pin2_mux_props_i (.sys_clk,
  .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .pin2_in, .pin2_out, .pin2_oe, .pin2_in_level);
`default_nettype wire

// ### gpom_pin2_mux_tb_top.sv
`default_nettype none
module gpom_pin2_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus, model and checks
  // ----------------------------------------------------------------
  logic sys_clk = 0, reset = 1, hsel = 0, hwrite = 0, frame_sync = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [3:0] rx_port_enable = 0;
  logic hreadyout, hresp, pin2_in, pin2_out, pin2_oe, pin2_in_level;
  gpom_pkg::gpom_rx_stat_t [3:0] rx_stat = '0;
  gpom_pkg::gpom_tx_stat_t [1:0] tx_stat = '0;
  int fails = 0, checks = 0, seed = 41;
  gpom_pin2_mux gpom_pin2_mux_i (.sys_clk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .rx_stat, .rx_port_enable, .frame_sync, .tx_stat, .pin2_in,
    .pin2_out, .pin2_oe, .pin2_in_level);
  gpom_board_model gpom_board_model_i (.pin_oe(pin2_oe), .pin_drv(pin2_out),
    .pin_level(pin2_in));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic test_done();
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // single word transfer; hready is the slave's own hreadyout
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= gpom_pkg::HTRANS_NONSEQ;
    hsize <= gpom_pkg::HSIZE_WORD;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    rd_q = hrdata;
  endtask
  function automatic logic ex(logic [7:0] c);
    int s = c[4:2];
    int v = c[7:5];
    logic [3:0] m, lk, ps;
    for (int i = 0; i < 4; i++) {lk[i], ps[i]} = rx_stat[i][3:2];
    m = s == 4 ? rx_port_enable : tx_stat[s[0]].pass_select;
    if (!c[0] || s == 5) return 1'h0;
    if (s < 4) return rx_stat[s][v < 4 ? 4 + v : 7 - v];
    if (s == 4)
      case (v)
        0: return c[1];
        1: return |(lk & m);
        2: return m != 0 && (lk & m) == m;
        3: return m != 0 && (ps & m) == m;
        4: return frame_sync;
        default: return 1'h0;
      endcase
    case (v)
      0: return m != 0 && (ps & m) == m;
      1: return |(ps & m);
      2, 3, 4, 5: return tx_stat[s[0]][5 - v];
      default: return 1'h0;
    endcase
  endfunction
  initial
  begin
    logic [63:0] r;
    repeat (10) @(posedge sys_clk);
    reset <= 1'h0;
    @(posedge sys_clk);
    xfer(1'h0, gpom_pkg::PIN2_CTRL_ADDR, '0);
    chk(rd_q, gpom_pkg::RDATA_ZERO);
    for (int i = 0; i < 256; i++)
    begin
      r = {$random(seed), $random(seed)};
      xfer(1'h1, gpom_pkg::PIN2_CTRL_ADDR, {r[31:8], i[7:0]});
      rx_stat <= r[31:0];
      tx_stat <= r[47:32];
      rx_port_enable <= r[51:48];
      frame_sync <= r[52];
      repeat (2) @(posedge sys_clk);
      chk(pin2_out, ex(i[7:0]));
      chk(pin2_out, ex(i[7:0]));
      chk(pin2_oe, i[0]);
      // board pin read back one cycle behind the driven level
      @(posedge sys_clk);
      chk(pin2_in_level, ex(i[7:0]));
      xfer(1'h1, 32'h0000_004C, 32'hFFFF_FFFF);
      xfer(1'h0, gpom_pkg::PIN2_CTRL_ADDR, '0);
      chk(rd_q, {24'h00_0000, i[7:0]});
      xfer(1'h0, 32'h0000_004C, '0);
      chk(rd_q, gpom_pkg::RDATA_ZERO);
    end
    reset <= 1'h1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    @(posedge sys_clk);
    chk(pin2_oe, 1'h0);
    xfer(1'h0, gpom_pkg::PIN2_CTRL_ADDR, '0);
    chk(rd_q, gpom_pkg::RDATA_ZERO);
    test_done();
  end
  initial
  begin
    #200_000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire

// ### gpom_pkg.sv
`default_nettype none
package gpom_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  // printed offset 0x12 is not a multiple of four: it is an index
  localparam logic [7:0] PIN2_CTRL_IDX = 8'h12;
  localparam logic [31:0] PIN2_CTRL_ADDR = 32'h0000_0048;
  localparam logic [7:0] PIN2_CTRL_RESET = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // ahb-lite codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HADDR_LSB_ZERO = 2'h0;

  // ----------------------------------------------------------------------
  // field layout of the control byte
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] pin2_signal_selector;
    logic [2:0] pin2_source_group;
    logic pin2_output_level;
    logic pin2_drive_enable;
  } gpom_ctrl_t;

  // ----------------------------------------------------------------------
  // source group codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SRC_RX0 = 3'h0;
  localparam logic [2:0] SRC_RX1 = 3'h1;
  localparam logic [2:0] SRC_RX2 = 3'h2;
  localparam logic [2:0] SRC_RX3 = 3'h3;
  localparam logic [2:0] SRC_DEV = 3'h4;
  localparam logic [2:0] SRC_RSVD = 3'h5;
  localparam logic [2:0] SRC_TX0 = 3'h6;
  localparam logic [2:0] SRC_TX1 = 3'h7;

  // ----------------------------------------------------------------------
  // signal selector codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1 = 3'h1;
  localparam logic [2:0] SEL_2 = 3'h2;
  localparam logic [2:0] SEL_3 = 3'h3;
  localparam logic [2:0] SEL_4 = 3'h4;
  localparam logic [2:0] SEL_5 = 3'h5;
  localparam logic [2:0] SEL_6 = 3'h6;
  localparam logic [2:0] SEL_7 = 3'h7;

  localparam int NUM_RX = 4;
  localparam int NUM_TX = 2;

  // ----------------------------------------------------------------------
  // status carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rx_remote_pin;
    logic lock;
    logic pass;
    logic frame_valid;
    logic line_valid;
  } gpom_rx_stat_t;

  typedef struct packed {
    logic [3:0] pass_select;
    logic frame_valid;
    logic line_valid;
    logic synced;
    logic irq;
  } gpom_tx_stat_t;

endpackage
`default_nettype wire
